// ==== test/test_ubef_event_flags.sv ====
// Self-checking bench for the USB bus event flag block
`timescale 1ns/1ps
module test_ubef_event_flags
    import ubef_pkg::*;
;
    typedef struct packed {
        logic [4:0] ev;
        logic [7:0] flag;
    } ubef_row_s;

    logic          sys_clk  = 1'b0;
    logic          reset_n  = 1'b0;
    logic          por_n    = 1'b0;
    logic          usb_tick = 1'b0;
    ubef_bus_ev_s  bus_ev   = '0;
    ubef_reg_req_s reg_req  = '0;
    logic [7:0]    reg_rdata;
    logic          event_irq;
    logic          block_irq;
    logic          setup_stall;
    logic          module_reset_req;
    int            mismatches = 0;
    int            tests_run  = 0;
    int            cycles     = 0;
    int            n;
    ubef_row_s     rows [4] = '{'{5'h10, 8'h80}, '{5'h08, 8'h40}, '{5'h04, 8'h20},
                                '{5'h02, 8'h10}};
    // Ticks from SOF to the pre-frame event for a lead of 255 steps before the frame boundary
    localparam int LEAD = int'(UBEF_FRAME_TICKS) - 255 * UBEF_PRESOF_STEP;

    ubef_event_flags dut (.sys_clk(sys_clk), .reset_n(reset_n), .por_n(por_n),
        .usb_tick(usb_tick), .bus_ev(bus_ev), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .event_irq(event_irq), .block_irq(block_irq), .setup_stall(setup_stall),
        .module_reset_req(module_reset_req));

    always #2.5 sys_clk = ~sys_clk;
    // USB tick every other cycle keeps the long pre-frame wait short
    always @(posedge sys_clk) usb_tick <= ~usb_tick;

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end

    // ************************************************************
    // Port tasks
    // ************************************************************
    // Inputs change by NBA at the edge; outputs are looked at 1 ns later
    task automatic step(input logic [3:0] a, input logic [7:0] d, input logic w,
                        input logic r, input ubef_bus_ev_s e);
        @(posedge sys_clk);
        reg_req <= '{a, d, w, r};
        bus_ev  <= e;
        #1;
    endtask
    task automatic idle();
        step(4'h0, 8'h00, 1'b0, 1'b0, 5'h00);
    endtask
    task automatic ev(input ubef_bus_ev_s e);
        step(4'h0, 8'h00, 1'b0, 1'b0, e);
        idle();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        step(a, d, 1'b1, 1'b0, 5'h00);
        idle();
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        step(a, 8'h00, 1'b0, 1'b1, 5'h00);
        idle();
        check(reg_rdata, exp, "reg_rdata");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        por_n   <= 1'b1;
        rd(UBEF_ADDR_FLAGS, 8'h00);
        rd(UBEF_ADDR_SOURCE, 8'h00);
        rd(UBEF_ADDR_ENABLE, 8'h00);
        $display("test reset values done");
        wr(UBEF_ADDR_ENABLE, 8'hFF);
        foreach (rows[i]) begin
            ev(rows[i].ev);
            idle();
            check(8'(event_irq), 8'h01, "event_irq");
            rd(UBEF_ADDR_FLAGS, rows[i].flag);
            // Back-to-back source reads: the second must see the flag gone
            step(UBEF_ADDR_SOURCE, 8'h00, 1'b0, 1'b1, 5'h00);
            step(UBEF_ADDR_SOURCE, 8'h00, 1'b0, 1'b1, 5'h00);
            check(reg_rdata, rows[i].flag, "source");
            idle();
            check(reg_rdata, 8'h00, "source");
            check(8'(event_irq), 8'h00, "event_irq");
        end
        $display("test event rows done");
        wr(UBEF_ADDR_ENABLE, 8'h00);
        ev(5'h08);
        idle();
        check(8'(event_irq), 8'h00, "event_irq");
        rd(UBEF_ADDR_SOURCE, 8'h00);
        step(UBEF_ADDR_FLAGS, 8'hFD, 1'b1, 1'b0, 5'h00);
        step(UBEF_ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 5'h00);
        idle();
        check(reg_rdata, 8'h00, "flags");
        $display("test masking done");
        wr(UBEF_ADDR_ENABLE, 8'h05);
        ev(5'h01);
        rd(UBEF_ADDR_FLAGS, 8'h04);
        rd(UBEF_ADDR_CONTROL, 8'h02);
        step(UBEF_ADDR_SOURCE, 8'h00, 1'b0, 1'b1, 5'h00);
        step(UBEF_ADDR_SOURCE, 8'h00, 1'b0, 1'b1, 5'h00);
        check(reg_rdata, 8'h04, "source");
        idle();
        check(reg_rdata, 8'h04, "source");
        ev(5'h01);
        check(8'(setup_stall), 8'h01, "setup_stall");
        rd(UBEF_ADDR_FLAGS, 8'h05);
        wr(UBEF_ADDR_FLAGS, 8'h02);
        rd(UBEF_ADDR_FLAGS, 8'h07);
        wr(UBEF_ADDR_FLAGS, 8'h05);
        rd(UBEF_ADDR_FLAGS, 8'h00);
        rd(UBEF_ADDR_CONTROL, 8'h00);
        $display("test setup done");
        step(UBEF_ADDR_FLAGS, 8'h10, 1'b1, 1'b0, 5'h02);
        step(UBEF_ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 5'h00);
        idle();
        check(reg_rdata, 8'h10, "flags");
        wr(UBEF_ADDR_FLAGS, 8'h10);
        $display("test set wins done");
        wr(UBEF_ADDR_CONTROL, 8'h10);
        ev(5'h08);
        ev(5'h10);
        check(8'(module_reset_req), 8'h01, "module_reset_req");
        rd(UBEF_ADDR_FLAGS, 8'h80);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(UBEF_ADDR_FLAGS, 8'h80);
        rd(UBEF_ADDR_ENABLE, 8'h00);
        $display("test function and module reset done");
        wr(UBEF_ADDR_ENABLE, 8'h08);
        wr(UBEF_ADDR_PRETMR, 8'hFF);
        ev(5'h02);
        n = 0;
        while (event_irq !== 1'b1 && n < 9000) begin
            @(posedge sys_clk);
            if (usb_tick) n++;
        end
        check(8'(n > LEAD - 5 && n < LEAD + 5), 8'h01, "lead ticks");
        rd(UBEF_ADDR_FLAGS, 8'h98);
        $display("test pre-frame timer done");
        // Module reset emptied the status; only the enabled pre-frame event is recorded
        check(8'(block_irq), 8'h00, "block_irq");
        rd(UBEF_ADDR_STATUS, 8'h01);
        wr(UBEF_ADDR_IRQEN, 8'h01);
        check(8'(block_irq), 8'h01, "block_irq");
        wr(UBEF_ADDR_CLEAR, 8'h01);
        check(8'(block_irq), 8'h00, "block_irq");
        rd(UBEF_ADDR_STATUS, 8'h00);
        rd(UBEF_ADDR_IRQEN, 8'h01);
        $display("test block interrupt done");
        final_report();
    end
endmodule

// ==== test/ubef_event_flags_sva.sv ====
// Checker for the USB bus event flag block, bound to its ports
`timescale 1ns/1ps
module ubef_event_flags_chk
    import ubef_pkg::*;
(
    input wire logic          sys_clk,
    input wire logic          reset_n,
    input wire ubef_bus_ev_s  bus_ev,
    input wire ubef_reg_req_s reg_req,
    input wire logic [7:0]    reg_rdata,
    input wire logic          event_irq,
    input wire logic          setup_stall,
    input wire logic          module_reset_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic rd_src;
    logic rd_flg;
    logic quiet;
    logic cause;
    assign rd_src = reg_req.rd && (reg_req.addr == UBEF_ADDR_SOURCE);
    assign rd_flg = reg_req.rd && (reg_req.addr == UBEF_ADDR_FLAGS);
    assign quiet  = (bus_ev == 5'h00);
    // Only software access or a function reset can take the level down
    assign cause  = reg_req.wr || reg_req.rd || bus_ev.bus_reset;

    stall_cause_a: assert property (setup_stall |-> $past(bus_ev.setup_rx))
        else $error("stall pulse without setup packet");
    freset_cause_a: assert property (module_reset_req |-> $past(bus_ev.bus_reset))
        else $error("function reset without bus reset");
    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    src_clear_a: assert property (rd_src && quiet ##1 rd_src && quiet
        |=> (reg_rdata & 8'hF0) == 8'h00)
        else $error("flag survived source read");
    setup_keep_a: assert property (rd_src && quiet ##1 rd_src && quiet
        |=> reg_rdata[2] == $past(reg_rdata[2]) && reg_rdata[0] == $past(reg_rdata[0]))
        else $error("setup flag lost on source read");
    irq_fall_a: assert property ($fell(event_irq) |-> $past(cause))
        else $error("interrupt dropped without cause");
    w1c_clear_a: assert property (reg_req.wr && reg_req.addr == UBEF_ADDR_FLAGS
        && reg_req.wdata == 8'hFD && quiet ##1 rd_flg && quiet |=> (reg_rdata & 8'hF5) == 8'h00)
        else $error("write one did not clear");
    set_wins_a: assert property (reg_req.wr && reg_req.addr == UBEF_ADDR_FLAGS
        && reg_req.wdata == 8'h10 && bus_ev.sof ##1 rd_flg |=> reg_rdata[4])
        else $error("clear beat a set");
endmodule

bind ubef_event_flags ubef_event_flags_chk chk (.sys_clk, .reset_n, .bus_ev, .reg_req,
    .reg_rdata, .event_irq, .setup_stall, .module_reset_req);

// ==== verilog/ubef_event_flags.sv ====
// USB bus event flag register with interrupt source read and enables
//
// Behaviour
// - Setup and overwrite flags ignore source reads
// - Other enabled flags clear on source read
// - Setup while setup flag set sets overwrite
// - Write one clears flag, reset zero
// - Host port reset sets bus-reset flag
// - Module reset keeps bus-reset flag
// - Suspend condition sets suspend flag
// - Resume request sets resume flag
// - SOF packet sets start-of-frame flag
// - Pre-frame flag at multiple of 16
// - Lead time from pre-frame timer register
// - Setup packet received sets setup flag
// - Clearing setup flag clears setup-not-ready
// - Enable bit gates each flag request
// - Function reset clears flags except bus-reset
// - Setup-not-ready answers setup with STALL
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ubef_event_flags
    import ubef_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          por_n,
    input  wire logic          usb_tick,
    input  wire ubef_bus_ev_s  bus_ev,
    input  wire ubef_reg_req_s reg_req,
    output logic [7:0]         reg_rdata,
    output logic               event_irq,
    output logic               block_irq,
    output logic               setup_stall,
    output logic               module_reset_req
);

    // ************************************************************
    // State
    // ************************************************************
    ubef_state_s s_q;
    ubef_state_s s_d;
    logic        busrst_q;
    logic        busrst_d;
    logic        frst_pulse_q;
    logic        presof_pulse;
    logic [7:0]  hw_set;
    logic [7:0]  flags_all;

    assign reg_rdata        = s_q.rdata;
    assign event_irq        = s_q.flag_irq;
    assign block_irq        = s_q.irq;
    assign setup_stall      = s_q.stall;
    assign module_reset_req = frst_pulse_q;

    ubef_presof_timer u_timer (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .usb_tick     (usb_tick),
        .sof_seen     (bus_ev.sof),
        .lead_steps   (s_q.pretmr),
        .presof_pulse (presof_pulse)
    );

    // ************************************************************
    // Hardware set terms
    // ************************************************************
    always_comb begin
        hw_set = 8'h00;
        hw_set[UBEF_BIT_BUSRST]  = bus_ev.bus_reset;
        hw_set[UBEF_BIT_SUSPEND] = bus_ev.suspend;
        hw_set[UBEF_BIT_RESUME]  = bus_ev.resume;
        hw_set[UBEF_BIT_SOF]     = bus_ev.sof;
        hw_set[UBEF_BIT_PRESOF]  = presof_pulse;
        // setup accepted only while buffer is ready
        hw_set[UBEF_BIT_SETUP]   = bus_ev.setup_rx & ~s_q.control[UBEF_CTL_SETUPNR];
        hw_set[UBEF_BIT_SETUP_OVERWRITE_FLAG]   = bus_ev.setup_rx & s_q.flags[UBEF_BIT_SETUP];
    end

    assign flags_all = {busrst_q, s_q.flags[6:0]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [7:0] clr;
        logic [7:0] fl;
        logic       wr_flags;
        logic       frst;
        logic [1:0] ev;
        clr      = 8'h00;
        fl       = 8'h00;
        wr_flags = 1'b0;
        frst     = 1'b0;
        ev       = 2'h0;
        s_d      = s_q;
        s_d.rdata = 8'h00;
        wr_flags = reg_req.wr && reg_req.addr == UBEF_ADDR_FLAGS;

        if (wr_flags) begin
            clr = reg_req.wdata & ~(8'h01 << UBEF_BIT_RSVD);
        end
        // source read clears the enabled plain event flags
        // setup and overwrite excluded from read clear
        if (reg_req.rd && reg_req.addr == UBEF_ADDR_SOURCE) begin
            clr = clr | (flags_all & s_q.enable
                  & ~((8'h01 << UBEF_BIT_SETUP) | (8'h01 << UBEF_BIT_SETUP_OVERWRITE_FLAG))
                  & ~(8'h01 << UBEF_BIT_RSVD));
        end
        frst = bus_ev.bus_reset & s_q.control[UBEF_CTL_FRST];
        if (frst) begin
            clr = clr | ~(8'h01 << UBEF_BIT_BUSRST) & ~(8'h01 << UBEF_BIT_RSVD);
        end
        // set wins over clear
        // Bus-reset bit comes from its own register so a module reset cannot lose it
        fl = (flags_all & ~clr) | hw_set;
        // Reserved bit is plain storage
        fl[UBEF_BIT_RSVD] = wr_flags ? reg_req.wdata[UBEF_BIT_RSVD] : s_q.flags[UBEF_BIT_RSVD];
        s_d.flags = fl;

        // clearing setup flag frees the buffer
        if (clr[UBEF_BIT_SETUP] && !hw_set[UBEF_BIT_SETUP]) begin
            s_d.control[UBEF_CTL_SETUPNR] = 1'b0;
        end
        if (hw_set[UBEF_BIT_SETUP]) begin
            s_d.control[UBEF_CTL_SETUPNR] = 1'b1;
        end

        if (reg_req.wr) begin
            unique case (reg_req.addr)
                UBEF_ADDR_ENABLE:  s_d.enable = reg_req.wdata;
                UBEF_ADDR_PRETMR:  s_d.pretmr = reg_req.wdata;
                UBEF_ADDR_IRQEN:   s_d.irq_en = reg_req.wdata[1:0];
                UBEF_ADDR_CONTROL: begin
                    // Not-ready bit is write-one-to-set only
                    s_d.control = {reg_req.wdata[7:2],
                                   s_d.control[UBEF_CTL_SETUPNR] | reg_req.wdata[1],
                                   reg_req.wdata[0]};
                end
                default: begin
                end
            endcase
        end

        s_d.stall = bus_ev.setup_rx & s_q.control[UBEF_CTL_SETUPNR];

        // Block-level sticky status; set beats the clear register
        ev[UBEF_EV_FLAG]  = |(hw_set & s_q.enable);
        ev[UBEF_EV_STALL] = bus_ev.setup_rx & s_q.control[UBEF_CTL_SETUPNR];
        if (reg_req.wr && reg_req.addr == UBEF_ADDR_CLEAR) begin
            s_d.irq_stat = (s_q.irq_stat & ~reg_req.wdata[1:0]) | ev;
        end else begin
            s_d.irq_stat = s_q.irq_stat | ev;
        end

        s_d.flag_irq = |({busrst_d, s_d.flags[6:0]} & s_d.enable
                         & ~(8'h01 << UBEF_BIT_RSVD));
        s_d.irq      = |(s_d.irq_stat & s_d.irq_en);

        if (reg_req.rd) begin
            unique case (reg_req.addr)
                UBEF_ADDR_FLAGS:   s_d.rdata = flags_all;
                UBEF_ADDR_SOURCE:  s_d.rdata = flags_all & s_q.enable;
                UBEF_ADDR_ENABLE:  s_d.rdata = s_q.enable;
                UBEF_ADDR_CONTROL: s_d.rdata = s_q.control;
                UBEF_ADDR_PRETMR:  s_d.rdata = s_q.pretmr;
                UBEF_ADDR_STATUS:  s_d.rdata = {6'h00, s_q.irq_stat};
                UBEF_ADDR_IRQEN:   s_d.rdata = {6'h00, s_q.irq_en};
                default:           s_d.rdata = 8'h00;
            endcase
        end
    end

    // bus-reset flag lives outside the module reset
    always_comb begin
        busrst_d = s_d.flags[UBEF_BIT_BUSRST];
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{flags: UBEF_FLAGS_RST, enable: UBEF_ENABLE_RST,
                     control: UBEF_CONTROL_RST, pretmr: UBEF_PRETMR_RST,
                     irq_stat: UBEF_IRQ_RST, irq_en: UBEF_IRQ_RST,
                     rdata: 8'h00, flag_irq: 1'b0, irq: 1'b0, stall: 1'b0};
            frst_pulse_q <= 1'b0;
        end else begin
            s_q          <= s_d;
            frst_pulse_q <= bus_ev.bus_reset & s_q.control[UBEF_CTL_FRST];
        end
    end

    // Of the two resets, only the power-on reset clears the bus-reset flag
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            busrst_q <= 1'b0;
        end else begin
            busrst_q <= busrst_d;
        end
    end

endmodule

// ==== verilog/ubef_pkg.sv ====
// Package for the USB bus event flag block: offsets, fields, types
package ubef_pkg;

    // ************************************************************
    // Register offsets (chosen, 8-bit register port)
    // ************************************************************
    localparam logic [3:0] UBEF_ADDR_FLAGS   = 4'h0;
    localparam logic [3:0] UBEF_ADDR_SOURCE  = 4'h1;
    localparam logic [3:0] UBEF_ADDR_ENABLE  = 4'h2;
    localparam logic [3:0] UBEF_ADDR_CONTROL = 4'h3;
    localparam logic [3:0] UBEF_ADDR_PRETMR  = 4'h4;
    localparam logic [3:0] UBEF_ADDR_STATUS  = 4'h5;
    localparam logic [3:0] UBEF_ADDR_CLEAR   = 4'h6;
    localparam logic [3:0] UBEF_ADDR_IRQEN   = 4'h7;

    // ************************************************************
    // Flag bit positions
    // ************************************************************
    localparam int UBEF_BIT_BUSRST  = 7;
    localparam int UBEF_BIT_SUSPEND = 6;
    localparam int UBEF_BIT_RESUME  = 5;
    localparam int UBEF_BIT_SOF     = 4;
    localparam int UBEF_BIT_PRESOF  = 3;
    localparam int UBEF_BIT_SETUP   = 2;
    localparam int UBEF_BIT_RSVD    = 1;
    localparam int UBEF_BIT_SETUP_OVERWRITE_FLAG   = 0;

    // Control register fields
    localparam int UBEF_CTL_FRST    = 4;
    localparam int UBEF_CTL_SETUPNR = 1;

    // Status register events (block-level interrupt unit)
    localparam int UBEF_EV_FLAG     = 0;
    localparam int UBEF_EV_STALL    = 1;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [7:0] UBEF_FLAGS_RST   = 8'h00;
    localparam logic [7:0] UBEF_ENABLE_RST  = 8'h00;
    localparam logic [7:0] UBEF_CONTROL_RST = 8'h00;
    localparam logic [7:0] UBEF_PRETMR_RST  = 8'h00;
    localparam logic [1:0] UBEF_IRQ_RST     = 2'h0;
    // Pre-frame lead time is counted in steps of this many USB clocks
    localparam int         UBEF_PRESOF_STEP = 16;
    localparam logic [3:0] UBEF_STEP_LAST   = 4'(UBEF_PRESOF_STEP - 1);
    // 1 ms frame at 12 MHz USB clock ticks
    localparam logic [13:0] UBEF_FRAME_TICKS = 14'h2EE0;

    // Bus events from the serial engine, one-cycle pulses
    typedef struct packed {
        logic bus_reset;
        logic suspend;
        logic resume;
        logic sof;
        logic setup_rx;
    } ubef_bus_ev_s;

    // Software register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ubef_reg_req_s;

    typedef enum logic [1:0] {
        UBEF_T_IDLE  = 2'b00,
        UBEF_T_COUNT = 2'b01,
        UBEF_T_FIRED = 2'b11
    } ubef_tstate_e;

    typedef struct packed {
        ubef_tstate_e st;
        logic [13:0]  left;
        logic [3:0]   sub;
        logic         fire;
    } ubef_tmr_s;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] enable;
        logic [7:0] control;
        logic [7:0] pretmr;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic [7:0] rdata;
        logic       flag_irq;
        logic       irq;
        logic       stall;
    } ubef_state_s;

endpackage

// ==== verilog/ubef_presof_timer.sv ====
// Pre-frame timer: pulses a programmed multiple of 16 ticks before SOF
`timescale 1ns/1ps
module ubef_presof_timer
    import ubef_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       usb_tick,
    input  wire logic       sof_seen,
    input  wire logic [7:0] lead_steps,
    output logic            presof_pulse
);

    ubef_tmr_s s_q;
    ubef_tmr_s s_d;

    assign presof_pulse = s_q.fire;

    always_comb begin
        s_d      = s_q;
        s_d.fire = 1'b0;
        if (sof_seen) begin
            // Each SOF restarts the frame count; a zero lead disables the event
            s_d.left = UBEF_FRAME_TICKS;
            s_d.sub  = 4'h0;
            s_d.st   = (lead_steps == 8'h00) ? UBEF_T_IDLE : UBEF_T_COUNT;
        end else if (usb_tick) begin
            unique case (s_q.st)
                UBEF_T_IDLE: begin
                end
                UBEF_T_COUNT: begin
                    if (s_q.left != 14'h0000) begin
                        s_d.left = s_q.left - 14'h0001;
                    end
                    s_d.sub = s_q.sub + 4'h1;
                    if (s_q.sub == UBEF_STEP_LAST
                        && s_q.left[13:4] <= {2'b00, lead_steps}) begin
                        s_d.fire = 1'b1;
                        s_d.st   = UBEF_T_FIRED;
                    end
                end
                UBEF_T_FIRED: begin
                end
                default: s_d.st = UBEF_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{st: UBEF_T_IDLE, left: 14'h0000, sub: 4'h0, fire: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

endmodule
